// ---- cfmbt_pkg.sv ----
// package for the mask-select and bit-timing block
// assumes byte-wide registers reached over a plain strobe port
package cfmbt_pkg;

	// ----------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------
	localparam logic [3:0] OFF_MSEL_4_7   = 4'h0;
	localparam logic [3:0] OFF_MSEL_8_11  = 4'h1;
	localparam logic [3:0] OFF_MSEL_12_15 = 4'h2;
	localparam logic [3:0] OFF_PRESCALE   = 4'h3;
	localparam logic [3:0] OFF_SEGMENTS   = 4'h4;
	localparam logic [3:0] OFF_WAKE_PH2   = 4'h5;
	localparam logic [3:0] OFF_PIN_CTRL   = 4'h6;
	localparam logic [3:0] OFF_MODE       = 4'h7;
	localparam logic [3:0] OFF_STATUS     = 4'h8;

	// ----------------------------------------------------------
	// reset values
	// ----------------------------------------------------------
	localparam logic [7:0] RST_MSEL_4_7   = 8'h05;
	localparam logic [7:0] RST_MSEL_8_11  = 8'h00;
	localparam logic [7:0] RST_MSEL_12_15 = 8'h00;
	localparam logic [7:0] RST_TIMING     = 8'h00;
	localparam logic [1:0] RST_OPMODE     = 2'h0;
	localparam logic       RST_CONFIG     = 1'b1;

	// ----------------------------------------------------------
	// field positions
	// ----------------------------------------------------------
	localparam int SJW_LSB     = 6;
	localparam int PH2SEL_BIT  = 7;
	localparam int TRIPLE_BIT  = 6;
	localparam int PH1_LSB     = 3;
	localparam int WAKE_DISABLE_BIT  = 7;
	localparam int WAKE_LINE_FILTER_BIT  = 6;
	localparam int DRVHI_BIT   = 5;
	localparam int CAPT_BIT    = 4;
	localparam logic [7:0] WAKE_PH2_MASK = 8'hc7;
	localparam logic [7:0] PIN_CTRL_MASK = 8'h30;

	// ----------------------------------------------------------
	// mask select codes, modes, timing
	// ----------------------------------------------------------
	localparam logic [1:0] SEL_MASK0  = 2'h0;
	localparam logic [1:0] SEL_MASK1  = 2'h1;
	localparam logic [1:0] SEL_FIL15  = 2'h2;
	localparam logic [1:0] SEL_NONE   = 2'h3;
	localparam logic [1:0] MODE_LEGACY = 2'h0;
	localparam logic [2:0] PROC_TIME_TQ = 3'h2;
	localparam logic [2:0] WAKE_FILT_LEN = 3'h4;

	typedef enum logic [1:0] {
		CFMBT_SYNC,
		CFMBT_PROP,
		CFMBT_PH1,
		CFMBT_PH2
	} cfmbt_seg_e;

endpackage

// ---- cfmbt_top.sv ----
// mask selection, bit timing, wake-up and pin routing of a can node
// assumes bus_rx and shared pin are asynchronous; all else on clk
// Notes on behaviour
// - select code picks mask0, mask1, filter15, none
// - four codes per byte, high filter topmost
// - timing registers writable in configuration mode only
// - jump width is one plus field quanta
// - quantum is two times (prescaler plus one)
// - clear select: phase2 = max(phase1, processing time)
// - triple sampling before sample point when set
// - phase1 lasts one plus field quanta
// - propagation lasts one plus field quanta
// - phase2 field used only when select set
// - wake disable bit blocks bus wake-up
// - wake filter bit filters line before detection
// - drive-high bit drives recessive, else float
// - capture bit routes receive signal to capture
// - unimplemented bits read zero, writes ignored
// - mask selects writable in configuration mode only
// - mask selects exist only in modes 1, 2, 3
`timescale 1ns/1ps
`default_nettype none

module cfmbt_top
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output var  logic [7:0] reg_rdata,
	input  wire logic       bus_rx,
	input  wire logic       tx_bit,
	input  wire logic       msg_rx_active,
	input  wire logic       shared_capture_pin,
	output var  logic       bus_transmit_pin_o,
	output var  logic       bus_transmit_pin_oe,
	output var  logic       capture_unit_in,
	output var  logic       rx_sample,
	output var  logic       sample_point,
	output var  logic       bus_wake,
	output var  logic [47:0] filter_mask_sel
);

	// ----------------------------------------------------------
	// registers
	// ----------------------------------------------------------
	logic [7:0]  msel_q [3];
	logic [7:0]  prescale_q;
	logic [7:0]  segments_q;
	logic [7:0]  wake_ph2_q;
	logic [7:0]  pin_ctrl_q;
	logic [1:0]  opmode_q;
	logic        config_q;
	logic        enhanced;
	logic        msel_addr;
	logic [1:0]  msel_idx;

	assign enhanced  = (opmode_q != cfmbt_pkg::MODE_LEGACY);
	assign msel_addr = (reg_addr <= cfmbt_pkg::OFF_MSEL_12_15);
	assign msel_idx  = reg_addr[1:0];

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			msel_q[0] <= cfmbt_pkg::RST_MSEL_4_7;
			msel_q[1] <= cfmbt_pkg::RST_MSEL_8_11;
			msel_q[2] <= cfmbt_pkg::RST_MSEL_12_15;
		end
		else if (reg_wr && msel_addr && config_q && enhanced)
		begin
			msel_q[msel_idx] <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prescale_q <= cfmbt_pkg::RST_TIMING;
			segments_q <= cfmbt_pkg::RST_TIMING;
			wake_ph2_q <= cfmbt_pkg::RST_TIMING;
		end
		else if (reg_wr && config_q)
		begin
			if (reg_addr == cfmbt_pkg::OFF_PRESCALE)
				prescale_q <= reg_wdata;
			else if (reg_addr == cfmbt_pkg::OFF_SEGMENTS)
				segments_q <= reg_wdata;
			else if (reg_addr == cfmbt_pkg::OFF_WAKE_PH2)
				wake_ph2_q <= reg_wdata & cfmbt_pkg::WAKE_PH2_MASK;
		end
	end

	// pin control and mode word are writable at any time
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_ctrl_q <= cfmbt_pkg::RST_TIMING;
			opmode_q   <= cfmbt_pkg::RST_OPMODE;
			config_q   <= cfmbt_pkg::RST_CONFIG;
		end
		else if (reg_wr)
		begin
			if (reg_addr == cfmbt_pkg::OFF_PIN_CTRL)
				pin_ctrl_q <= reg_wdata & cfmbt_pkg::PIN_CTRL_MASK;
			else if (reg_addr == cfmbt_pkg::OFF_MODE)
			begin
				config_q <= reg_wdata[7];
				opmode_q <= reg_wdata[1:0];
			end
		end
	end

	// ----------------------------------------------------------
	// register read, one cycle after the strobe
	// ----------------------------------------------------------
	logic [7:0] rd_d;
	logic [1:0] seg_code;

	always_comb
	begin
		rd_d = 8'h00;
		if (msel_addr)
			rd_d = enhanced ? msel_q[msel_idx] : 8'h00;
		else if (reg_addr == cfmbt_pkg::OFF_PRESCALE)
			rd_d = prescale_q;
		else if (reg_addr == cfmbt_pkg::OFF_SEGMENTS)
			rd_d = segments_q;
		else if (reg_addr == cfmbt_pkg::OFF_WAKE_PH2)
			rd_d = wake_ph2_q;
		else if (reg_addr == cfmbt_pkg::OFF_PIN_CTRL)
			rd_d = pin_ctrl_q;
		else if (reg_addr == cfmbt_pkg::OFF_MODE)
			rd_d = {config_q, 5'h00, opmode_q};
		else if (reg_addr == cfmbt_pkg::OFF_STATUS)
			rd_d = {4'h0, bus_wake, rx_sample, seg_code};
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= reg_rd ? rd_d : 8'h00;
	end

	// ----------------------------------------------------------
	// mask select decode per filter 4..15
	// ----------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 12; gi++)
		begin : g_sel
			logic [1:0] code;
			assign code = msel_q[gi / 4][(gi % 4) * 2 +: 2];
			// one-hot in modes 1, 2, 3: mask0, mask1, filter15, none; all zero in legacy mode
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					filter_mask_sel[gi*4 +: 4] <= 4'h0;
				else if (!enhanced)
					filter_mask_sel[gi*4 +: 4] <= 4'h0;
				else
					filter_mask_sel[gi*4 +: 4] <= 4'h1 << code;
			end
		end
	endgenerate

	// ----------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------
	logic [1:0] rx_sync_q;
	logic [1:0] pin_sync_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_sync_q  <= 2'b11;
			pin_sync_q <= 2'b00;
		end
		else
		begin
			rx_sync_q  <= {rx_sync_q[0], bus_rx};
			pin_sync_q <= {pin_sync_q[0], shared_capture_pin};
		end
	end

	logic rx_s;
	logic rx_prev_q;
	assign rx_s = rx_sync_q[1];

	// ----------------------------------------------------------
	// time quantum prescaler
	// ----------------------------------------------------------
	logic [6:0] tq_cnt_q;
	logic [6:0] tq_len;
	logic       tq_tick;

	// two times (field + 1) oscillator cycles
	assign tq_len  = {prescale_q[5:0], 1'b1};
	assign tq_tick = (tq_cnt_q == tq_len);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			tq_cnt_q <= 7'h00;
		else if (tq_tick)
			tq_cnt_q <= 7'h00;
		else
			tq_cnt_q <= tq_cnt_q + 7'h01;
	end

	// ----------------------------------------------------------
	// segment lengths
	// ----------------------------------------------------------
	logic [3:0] prop_len;
	logic [3:0] ph1_len;
	logic [3:0] ph2_len;
	logic [3:0] sjw_len;
	logic [3:0] ipt_len;

	assign prop_len = {1'b0, segments_q[2:0]} + 4'h1;
	assign ph1_len  = {1'b0, segments_q[cfmbt_pkg::PH1_LSB +: 3]} + 4'h1;
	assign sjw_len  = {2'b00, prescale_q[cfmbt_pkg::SJW_LSB +: 2]} + 4'h1;
	assign ipt_len  = {1'b0, cfmbt_pkg::PROC_TIME_TQ};

	always_comb
	begin
		if (segments_q[cfmbt_pkg::PH2SEL_BIT])
			ph2_len = {1'b0, wake_ph2_q[2:0]} + 4'h1;
		else
			ph2_len = (ph1_len > ipt_len) ? ph1_len : ipt_len;
	end

	// ----------------------------------------------------------
	// bit timing state machine
	// ----------------------------------------------------------
	cfmbt_pkg::cfmbt_seg_e seg_q;
	logic [4:0] q_cnt_q;
	logic [4:0] ph1_ext_q;
	logic       edge_fall;
	logic [4:0] err;
	logic [4:0] adj;

	assign seg_code  = seg_q;
	assign edge_fall = rx_prev_q && !rx_s;

	// phase error in quanta, clipped to the jump width
	always_comb
	begin
		err = 5'h00;
		if (seg_q == cfmbt_pkg::CFMBT_PROP || seg_q == cfmbt_pkg::CFMBT_PH1)
			err = q_cnt_q + 5'h01;
		else if (seg_q == cfmbt_pkg::CFMBT_PH2)
			err = {1'b0, ph2_len} - q_cnt_q;
		adj = (err > {1'b0, sjw_len}) ? {1'b0, sjw_len} : err;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rx_prev_q <= 1'b1;
		else
			rx_prev_q <= rx_s;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			seg_q     <= cfmbt_pkg::CFMBT_SYNC;
			q_cnt_q   <= 5'h00;
			ph1_ext_q <= 5'h00;
		end
		else if (edge_fall && seg_q == cfmbt_pkg::CFMBT_PH2)
		begin
			// early edge: cut phase 2 by up to the jump width; restart the bit if that ends it
			if (adj >= {1'b0, ph2_len} - q_cnt_q)
			begin
				seg_q   <= cfmbt_pkg::CFMBT_PROP;
				q_cnt_q <= 5'h00;
			end
			else
				q_cnt_q <= q_cnt_q + adj;
			ph1_ext_q <= 5'h00;
		end
		else if (edge_fall && seg_q != cfmbt_pkg::CFMBT_SYNC
			&& ph1_ext_q == 5'h00)
		begin
			ph1_ext_q <= adj;
		end
		else if (tq_tick)
		begin
			case (seg_q)
				cfmbt_pkg::CFMBT_SYNC:
				begin
					seg_q   <= cfmbt_pkg::CFMBT_PROP;
					q_cnt_q <= 5'h00;
				end
				cfmbt_pkg::CFMBT_PROP:
				begin
					if (q_cnt_q + 5'h01 >= {1'b0, prop_len})
					begin
						seg_q   <= cfmbt_pkg::CFMBT_PH1;
						q_cnt_q <= 5'h00;
					end
					else
						q_cnt_q <= q_cnt_q + 5'h01;
				end
				cfmbt_pkg::CFMBT_PH1:
				begin
					if (q_cnt_q + 5'h01 >= {1'b0, ph1_len} + ph1_ext_q)
					begin
						seg_q   <= cfmbt_pkg::CFMBT_PH2;
						q_cnt_q <= 5'h00;
					end
					else
						q_cnt_q <= q_cnt_q + 5'h01;
				end
				default:
				begin
					if (q_cnt_q + 5'h01 >= {1'b0, ph2_len})
					begin
						seg_q     <= cfmbt_pkg::CFMBT_SYNC;
						q_cnt_q   <= 5'h00;
						ph1_ext_q <= 5'h00;
					end
					else
						q_cnt_q <= q_cnt_q + 5'h01;
				end
			endcase
		end
	end

	// ----------------------------------------------------------
	// sampling
	// ----------------------------------------------------------
	logic       sp_now;
	logic [2:0] samp_q;
	logic       maj;

	assign sp_now = tq_tick && seg_q == cfmbt_pkg::CFMBT_PH1
		&& (q_cnt_q + 5'h01 >= {1'b0, ph1_len} + ph1_ext_q);
	assign maj = (samp_q[0] & samp_q[1]) | (samp_q[0] & samp_q[2])
		| (samp_q[1] & samp_q[2]);

	// shift in one sample per quantum; last three precede the point
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			samp_q <= 3'b111;
		else if (tq_tick)
			samp_q <= {samp_q[1:0], rx_s};
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_sample    <= 1'b1;
			sample_point <= 1'b0;
		end
		else
		begin
			sample_point <= sp_now;
			if (sp_now)
				rx_sample <= segments_q[cfmbt_pkg::TRIPLE_BIT]
					? maj : rx_s;
		end
	end

	// ----------------------------------------------------------
	// wake-up detection
	// ----------------------------------------------------------
	// filter needs the low level for several clocks, rejecting glitches
	logic [2:0] low_cnt_q;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			low_cnt_q <= 3'h0;
		else if (rx_s)
			low_cnt_q <= 3'h0;
		else if (low_cnt_q != cfmbt_pkg::WAKE_FILT_LEN)
			low_cnt_q <= low_cnt_q + 3'h1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			bus_wake <= 1'b0;
		else if (wake_ph2_q[cfmbt_pkg::WAKE_DISABLE_BIT])
			bus_wake <= 1'b0;
		else if (wake_ph2_q[cfmbt_pkg::WAKE_LINE_FILTER_BIT])
			bus_wake <= (low_cnt_q == cfmbt_pkg::WAKE_FILT_LEN);
		else
			bus_wake <= !rx_s;
	end

	// ----------------------------------------------------------
	// pin drive and capture routing
	// ----------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bus_transmit_pin_o  <= 1'b1;
			bus_transmit_pin_oe <= 1'b0;
			capture_unit_in     <= 1'b0;
		end
		else
		begin
			bus_transmit_pin_o  <= tx_bit;
			// recessive is one: float unless drive-high set
			bus_transmit_pin_oe <= !tx_bit
				|| pin_ctrl_q[cfmbt_pkg::DRVHI_BIT];
			capture_unit_in <= pin_ctrl_q[cfmbt_pkg::CAPT_BIT]
				? msg_rx_active : pin_sync_q[1];
		end
	end

endmodule

`default_nettype wire

// ---- cfmbt_checker.sv ----
// port checker for the mask-select and bit-timing block
// assumes it is bound onto cfmbt_top, one clock, reset active low
`timescale 1ns/1ps
`default_nettype none

module cfmbt_checker
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [3:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        bus_rx,
	input wire logic        tx_bit,
	input wire logic        msg_rx_active,
	input wire logic        shared_capture_pin,
	input wire logic        bus_transmit_pin_o,
	input wire logic        bus_transmit_pin_oe,
	input wire logic        capture_unit_in,
	input wire logic        rx_sample,
	input wire logic        sample_point,
	input wire logic        bus_wake,
	input wire logic [47:0] filter_mask_sel
);
	// ----------------------------------------------------------
	// shadows of the control words, seen from the port only
	// ----------------------------------------------------------
	logic [7:0] mode_q;
	logic [7:0] wk_q;
	logic [7:0] pin_q;
	logic       sel_ok;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_q <= 8'h80;
			wk_q   <= 8'h00;
			pin_q  <= 8'h00;
		end
		else if (reg_wr)
		begin
			if (reg_addr == cfmbt_pkg::OFF_MODE)
				mode_q <= reg_wdata;
			// timing word only moves in configuration mode
			if (reg_addr == cfmbt_pkg::OFF_WAKE_PH2 && mode_q[7])
				wk_q <= reg_wdata;
			if (reg_addr == cfmbt_pkg::OFF_PIN_CTRL)
				pin_q <= reg_wdata;
		end
	end

	always_comb
	begin
		sel_ok = 1'b1;
		for (int i = 0; i < 12; i++)
			if ($countones(filter_mask_sel[i*4+:4]) > 1)
				sel_ok = 1'b0;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	AST_SEL_ONEHOT: assert property (sel_ok)
		else $error("mask select not one-hot");
	AST_MODE0_NONE: assert property (
		(mode_q[1:0] == 2'h0) [*2] |-> filter_mask_sel == 48'h0)
		else $error("mask select live in legacy mode");
	AST_WAKE_RSV: assert property (
		reg_rd && reg_addr == cfmbt_pkg::OFF_WAKE_PH2
		|=> (reg_rdata & ~cfmbt_pkg::WAKE_PH2_MASK) == 8'h00)
		else $error("wake word reserved bits not zero");
	AST_PIN_RSV: assert property (
		reg_rd && reg_addr == cfmbt_pkg::OFF_PIN_CTRL
		|=> (reg_rdata & ~cfmbt_pkg::PIN_CTRL_MASK) == 8'h00)
		else $error("pin word reserved bits not zero");
	AST_DOM_DRIVEN: assert property (
		!bus_transmit_pin_o |-> bus_transmit_pin_oe)
		else $error("dominant level not driven");
	AST_REC_FLOAT: assert property (
		(!pin_q[cfmbt_pkg::DRVHI_BIT]) [*2]
		|-> !(bus_transmit_pin_oe && bus_transmit_pin_o))
		else $error("recessive driven with drive-high clear");
	AST_CAPT_ROUTE: assert property (
		pin_q[cfmbt_pkg::CAPT_BIT] [*2]
		|-> capture_unit_in == $past(msg_rx_active))
		else $error("capture not fed by receive signal");
	AST_WAKE_OFF: assert property (
		wk_q[cfmbt_pkg::WAKE_DISABLE_BIT] [*3] |-> !bus_wake)
		else $error("wake while disabled");
	AST_SP_SPACING: assert property (
		sample_point |=> !sample_point [*3])
		else $error("sample points too close");
	AST_RX_AT_SP: assert property (
		$changed(rx_sample) |-> sample_point or ##1 sample_point)
		else $error("sampled bit moved off the sample point");

	COV_SP: cover property (sample_point);
	COV_WAKE: cover property (bus_wake);
	COV_CAPT: cover property (pin_q[cfmbt_pkg::CAPT_BIT] && capture_unit_in);
endmodule

bind cfmbt_top cfmbt_checker u_chk
(
	.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .bus_rx(bus_rx), .tx_bit(tx_bit),
	.msg_rx_active(msg_rx_active),
	.shared_capture_pin(shared_capture_pin),
	.bus_transmit_pin_o(bus_transmit_pin_o),
	.bus_transmit_pin_oe(bus_transmit_pin_oe),
	.capture_unit_in(capture_unit_in), .rx_sample(rx_sample),
	.sample_point(sample_point), .bus_wake(bus_wake),
	.filter_mask_sel(filter_mask_sel)
);

`default_nettype wire

// ---- cfmbt_bus_model.sv ----
// can line model: pull-up to recessive, wired-and of two nodes
// assumes pin enable is high while the node drives its pin
`timescale 1ns/1ps
`default_nettype none

module cfmbt_bus_model
(
	input  wire logic pin_o,
	input  wire logic pin_oe,
	input  wire logic far_dominant,
	output var  logic bus_rx
);
	// a floated pin leaves the pull-up in charge, so recessive
	assign bus_rx = !(pin_oe && !pin_o) && !far_dominant;
endmodule

`default_nettype wire

// ---- tb_can_filter_mask_and_bit_timing.sv ----
// self-checking bench for cfmbt_top over its register port
// assumes the bus model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) \
	begin \
		n_compared++; \
		if ((gt) !== (ex)) \
		begin \
			failures++; \
			$display("BAD %s exp %h got %h", nm, ex, gt); \
		end \
	end

module tb_can_filter_mask_and_bit_timing;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        tx_bit = 1'b1;
	logic        msg_rx_active = 1'b0;
	logic        shared_capture_pin = 1'b0;
	logic        far_dom = 1'b0;
	logic [7:0]  reg_rdata;
	logic        bus_rx;
	logic        tx_o;
	logic        tx_oe;
	logic        capt;
	logic        rx_sample;
	logic        sample_point;
	logic        bus_wake;
	logic [47:0] filter_mask_sel;
	int          failures = 0;
	int          n_compared = 0;
	// prescale, segments, wake word, expected clocks per bit
	logic [39:0] tt [5] = '{40'h3f_07_00_0600, 40'h00_88_01_000c,
		40'h00_18_07_0014, 40'h00_00_07_000a, 40'hc1_98_00_001c};

	always #50 clk = ~clk;

	cfmbt_top uut
	(
		.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .bus_rx(bus_rx), .tx_bit(tx_bit),
		.msg_rx_active(msg_rx_active),
		.shared_capture_pin(shared_capture_pin),
		.bus_transmit_pin_o(tx_o), .bus_transmit_pin_oe(tx_oe),
		.capture_unit_in(capt), .rx_sample(rx_sample),
		.sample_point(sample_point), .bus_wake(bus_wake),
		.filter_mask_sel(filter_mask_sel)
	);

	cfmbt_bus_model u_bus
	(
		.pin_o(tx_o), .pin_oe(tx_oe), .far_dominant(far_dom),
		.bus_rx(bus_rx)
	);

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// one strobe cycle, then one idle edge before the next call
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
	begin
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
		@(posedge clk);
	end
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] ex);
	begin
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		@(posedge clk);
		`CHK("reg_rdata", ex, reg_rdata)
	end
	endtask

	task automatic bitlen(input logic [15:0] ex);
		logic [15:0] n;
	begin
		// first intervals only align to the new timing
		for (int k = 0; k < 3; k++)
		begin
			n = 16'h0;
			do
			begin
				@(posedge clk);
				n++;
			end
			while (sample_point !== 1'b1 && n < 16'h1000);
		end
		`CHK("bit_clocks", ex, n)
	end
	endtask

	task automatic wake(input logic [7:0] wk, input int len,
		input logic ex);
		logic seen;
	begin
		seen = 1'b0;
		wr(cfmbt_pkg::OFF_MODE, 8'h81);
		wr(cfmbt_pkg::OFF_WAKE_PH2, wk);
		wr(cfmbt_pkg::OFF_MODE, 8'h01);
		far_dom <= 1'b1;
		repeat (len) @(posedge clk) seen |= bus_wake;
		far_dom <= 1'b0;
		repeat (8) @(posedge clk) seen |= bus_wake;
		`CHK("bus_wake", ex, seen)
	end
	endtask

	task automatic summarize();
	begin
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask

	initial
	begin
		#(100 * 20000);
		failures++;
		summarize();
	end

	initial
	begin
		cyc(4);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 3; i++)
			rd(4'(i), 8'h00);
		rd(cfmbt_pkg::OFF_MODE, 8'h80);
		wr(cfmbt_pkg::OFF_MODE, 8'h81);
		rd(cfmbt_pkg::OFF_MSEL_4_7, cfmbt_pkg::RST_MSEL_4_7);
		wr(cfmbt_pkg::OFF_MSEL_4_7, 8'he4);
		wr(cfmbt_pkg::OFF_MSEL_8_11, 8'h1b);
		wr(cfmbt_pkg::OFF_MSEL_12_15, 8'h93);
		rd(cfmbt_pkg::OFF_MSEL_12_15, 8'h93);
		`CHK("mask_sel", 48'h4218_1248_8421, filter_mask_sel)
		wr(cfmbt_pkg::OFF_MODE, 8'h01);
		wr(cfmbt_pkg::OFF_MSEL_4_7, 8'h00);
		rd(cfmbt_pkg::OFF_MSEL_4_7, 8'he4);
		for (int i = 3; i < 6; i++)
			wr(4'(i), 8'hff);
		for (int i = 3; i < 6; i++)
			rd(4'(i), 8'h00);
		wr(cfmbt_pkg::OFF_MODE, 8'h00);
		rd(cfmbt_pkg::OFF_MSEL_4_7, 8'h00);
		`CHK("mask_sel", 48'h0, filter_mask_sel)
		wr(4'hf, 8'hff);
		rd(4'hf, 8'h00);
		wr(cfmbt_pkg::OFF_MODE, 8'h81);
		wr(cfmbt_pkg::OFF_WAKE_PH2, 8'hff);
		rd(cfmbt_pkg::OFF_WAKE_PH2, cfmbt_pkg::WAKE_PH2_MASK);
		wr(cfmbt_pkg::OFF_PIN_CTRL, 8'hff);
		rd(cfmbt_pkg::OFF_PIN_CTRL, cfmbt_pkg::PIN_CTRL_MASK);
		msg_rx_active <= 1'b1;
		cyc(3);
		`CHK("tx_oe", 1'b1, tx_oe)
		`CHK("tx_o", 1'b1, tx_o)
		`CHK("capture", 1'b1, capt)
		wr(cfmbt_pkg::OFF_PIN_CTRL, 8'h00);
		cyc(3);
		`CHK("tx_oe", 1'b0, tx_oe)
		`CHK("capture", 1'b0, capt)
		shared_capture_pin <= 1'b1;
		tx_bit <= 1'b0;
		cyc(4);
		`CHK("capture", 1'b1, capt)
		`CHK("tx_oe", 1'b1, tx_oe)
		`CHK("tx_o", 1'b0, tx_o)
		tx_bit <= 1'b1;
		foreach (tt[i])
		begin
			wr(cfmbt_pkg::OFF_MODE, 8'h81);
			wr(cfmbt_pkg::OFF_PRESCALE, tt[i][39:32]);
			wr(cfmbt_pkg::OFF_SEGMENTS, tt[i][31:24]);
			wr(cfmbt_pkg::OFF_WAKE_PH2, tt[i][23:16]);
			wr(cfmbt_pkg::OFF_MODE, 8'h01);
			bitlen(tt[i][15:0]);
		end
		for (int s = 0; s < 2; s++)
		begin
			wr(cfmbt_pkg::OFF_MODE, 8'h81);
			wr(cfmbt_pkg::OFF_SEGMENTS, s ? 8'hd8 : 8'h98);
			wr(cfmbt_pkg::OFF_MODE, 8'h01);
			far_dom <= 1'b1;
			cyc(60);
			`CHK("rx_sample", 1'b0, rx_sample)
			far_dom <= 1'b0;
			cyc(60);
			`CHK("rx_sample", 1'b1, rx_sample)
		end
		wake(8'h00, 2, 1'b1);
		wake(8'h40, 2, 1'b0);
		wake(8'h40, 8, 1'b1);
		wake(8'h80, 8, 1'b0);
		summarize();
	end
endmodule

`default_nettype wire
